/* File: ebpfs_pad_model.sv */
`timescale 1ns/1ps
// Board side of the shared pins: external parts drive any pad the chip leaves released
module ebpfs_pad_model (
    input  wire logic [ebpfs_pkg::NPINS-1:0] padOut,
    input  wire logic [ebpfs_pkg::NPINS-1:0] padOe,
    input  wire logic [ebpfs_pkg::NPINS-1:0] extVal,
    output logic      [ebpfs_pkg::NPINS-1:0] padIn
);
    // Wire level per pad
    always_comb
    begin
        padIn = (padOut & padOe) | (extVal & ~padOe);
    end
endmodule

/* File: ebpfs_pin_mux.sv */
`timescale 1ns/1ps
// Overview of operation
// - Bit 11 routes chip select one
// - Bit 13 picks external clock on top pin unless span is 111
// - Bits 15:14 value 01 gives chip select two
// - Bits 17:16 value 01 gives chip select three
// - Bit 20 clear keeps data pair GPIO
// - Bit 22 routes top data pin analog five
// - Bit 23 address zero, strap 00 sets
// - Bit 24 address one, loads upper strap
// - Bits 27:25 set upper address line span
// - Span resets 000 on strap 11, else 111
// - Wide data bus overrides bits 20 to 22
// - GPIO direction only while GPIO selected
module ebpfs_pin_mux (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic [31:0]                   regAddr,
    input  wire logic [31:0]                   regWdata,
    input  wire logic                          regWrEn,
    input  wire logic                          regRdEn,
    output logic      [31:0]                   regRdata,
    input  wire logic [1:0]                    bootStrapPins,
    input  wire logic [1:0]                    dataBusCfg,
    input  wire logic [ebpfs_pkg::NPINS-1:0]   gpioDir,
    input  wire logic [ebpfs_pkg::NPINS-1:0]   gpioOut,
    output logic      [ebpfs_pkg::NPINS-1:0]   gpioIn,
    input  wire logic [ebpfs_pkg::NPINS-1:0]   memOut,
    input  wire logic [ebpfs_pkg::NPINS-1:0]   memOe,
    input  wire logic                          extClkIn,
    input  wire logic [ebpfs_pkg::NPINS-1:0]   padIn,
    output logic      [ebpfs_pkg::NPINS-1:0]   padOut,
    output logic      [ebpfs_pkg::NPINS-1:0]   padOe,
    output logic      [1:0]                    analogEnable
);

    logic                          csOne_q;
    logic                          eclkSel_q;
    logic [1:0]                    csTwo_q;
    logic [1:0]                    csThree_q;
    logic                          dPair_q;
    logic                          ainFour_q;
    logic                          ainFive_q;
    logic                          aZero_q;
    logic                          aOne_q;
    logic [2:0]                    addrCnt_q;
    logic                          strapLoad_q;
    logic [1:0]                    strapSync;
    logic                          wrHit;
    logic                          rdHit;
    logic [31:0]                   regImage;
    logic [31:0]                   regRdata_q;
    logic [ebpfs_pkg::NPINS-1:0]   padOut_q;
    logic [ebpfs_pkg::NPINS-1:0]   padOe_q;
    logic [1:0]                    analogEnable_q;
    ebpfs_pkg::ebpfs_role_t        role [ebpfs_pkg::NPINS];
    logic                          wideBus;

    assign wrHit        = regWrEn && (regAddr == ebpfs_pkg::REG_OFF);
    assign rdHit        = regRdEn && (regAddr == ebpfs_pkg::REG_OFF);
    assign wideBus      = (dataBusCfg == ebpfs_pkg::DBUS_WIDE);
    assign regRdata     = regRdata_q;
    assign padOut       = padOut_q;
    assign padOe        = padOe_q;
    assign analogEnable = analogEnable_q;

    // Strap and pad synchronisers
    ebpfs_sync2 #(
        .W        (2)
    ) u_strap_sync (
        .core_clk (core_clk),
        .asyncIn  (bootStrapPins),
        .syncOut  (strapSync)
    );

    ebpfs_sync2 #(
        .W        (ebpfs_pkg::NPINS)
    ) u_pad_sync (
        .core_clk (core_clk),
        .asyncIn  (padIn),
        .syncOut  (gpioIn)
    );

    // One shot strap capture after release
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            strapLoad_q <= 1'b1;
        else
            strapLoad_q <= 1'b0;
    end

    // Plain pin function fields
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            csOne_q   <= ebpfs_pkg::RST_CS_ONE;
            eclkSel_q <= ebpfs_pkg::RST_ECLK;
            csTwo_q   <= ebpfs_pkg::RST_CS_TWO;
            csThree_q <= ebpfs_pkg::RST_CS_THREE;
            dPair_q   <= ebpfs_pkg::RST_DPAIR;
            ainFour_q <= ebpfs_pkg::RST_AIN_FOUR;
            ainFive_q <= ebpfs_pkg::RST_AIN_FIVE;
        end
        else if (wrHit)
        begin
            csOne_q   <= regWdata[ebpfs_pkg::BIT_CS_ONE];
            eclkSel_q <= regWdata[ebpfs_pkg::BIT_ECLK];
            csTwo_q   <= regWdata[ebpfs_pkg::CS_TWO_LSB +: 2];
            csThree_q <= regWdata[ebpfs_pkg::CS_THREE_LSB +: 2];
            dPair_q   <= regWdata[ebpfs_pkg::BIT_DPAIR];
            ainFour_q <= regWdata[ebpfs_pkg::BIT_AIN_FOUR];
            ainFive_q <= regWdata[ebpfs_pkg::BIT_AIN_FIVE];
        end
    end

    // Strap dependent address fields
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aZero_q   <= ebpfs_pkg::RST_A_ZERO;
            aOne_q    <= ebpfs_pkg::RST_A_ONE;
            addrCnt_q <= ebpfs_pkg::RST_ACNT;
        end
        else if (wrHit)
        begin
            aZero_q   <= regWdata[ebpfs_pkg::BIT_A_ZERO];
            aOne_q    <= regWdata[ebpfs_pkg::BIT_A_ONE];
            addrCnt_q <= regWdata[ebpfs_pkg::ACNT_LSB +: 3];
        end
        else if (strapLoad_q)
        begin
            aZero_q   <= (strapSync == ebpfs_pkg::STRAP_A_ZERO);
            aOne_q    <= strapSync[1];
            addrCnt_q <= (strapSync == ebpfs_pkg::STRAP_NO_ADR) ?
                         ebpfs_pkg::ACNT_NONE : ebpfs_pkg::ACNT_ALL;
        end
    end

    // Read image
    always_comb
    begin
        regImage = 32'h0;
        regImage[ebpfs_pkg::BIT_CS_ONE]          = csOne_q;
        regImage[ebpfs_pkg::BIT_ECLK]            = eclkSel_q;
        regImage[ebpfs_pkg::CS_TWO_LSB +: 2]     = csTwo_q;
        regImage[ebpfs_pkg::CS_THREE_LSB +: 2]   = csThree_q;
        regImage[ebpfs_pkg::BIT_DPAIR]           = dPair_q;
        regImage[ebpfs_pkg::BIT_AIN_FOUR]        = ainFour_q;
        regImage[ebpfs_pkg::BIT_AIN_FIVE]        = ainFive_q;
        regImage[ebpfs_pkg::BIT_A_ZERO]          = aZero_q;
        regImage[ebpfs_pkg::BIT_A_ONE]           = aOne_q;
        regImage[ebpfs_pkg::ACNT_LSB +: 3]       = addrCnt_q;
    end

    // Read data, zero for unmapped
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            regRdata_q <= 32'h0;
        else if (rdHit)
            regRdata_q <= regImage;
        else
            regRdata_q <= 32'h0;
    end

    // Role of each shared pin
    always_comb
    begin
        for (int i = 0; i < ebpfs_pkg::NPINS; i++)
        begin
            role[i] = ebpfs_pkg::ROLE_GPIO;
        end
        if (csOne_q)
            role[ebpfs_pkg::IDX_CS_ONE] = ebpfs_pkg::ROLE_MEM;
        if (csTwo_q == ebpfs_pkg::CS_FUNC_ON)
            role[ebpfs_pkg::IDX_CS_TWO] = ebpfs_pkg::ROLE_MEM;
        if (csThree_q == ebpfs_pkg::CS_FUNC_ON)
            role[ebpfs_pkg::IDX_CS_THREE] = ebpfs_pkg::ROLE_MEM;
        if (aZero_q)
            role[ebpfs_pkg::IDX_A_ZERO] = ebpfs_pkg::ROLE_MEM;
        if (aOne_q)
            role[ebpfs_pkg::IDX_A_ONE] = ebpfs_pkg::ROLE_MEM;
        for (int n = 2; n < 23; n++)
        begin
            if (n <= ebpfs_pkg::addrTop(addrCnt_q))
                role[ebpfs_pkg::IDX_A_TWO + n - 2] = ebpfs_pkg::ROLE_MEM;
        end
        if (addrCnt_q == ebpfs_pkg::ACNT_ALL)
            role[ebpfs_pkg::IDX_A_TOP] = ebpfs_pkg::ROLE_MEM;
        else if (eclkSel_q)
            role[ebpfs_pkg::IDX_A_TOP] = ebpfs_pkg::ROLE_CLK;
        if (wideBus)
        begin
            for (int k = ebpfs_pkg::IDX_D_PAIR; k <= ebpfs_pkg::IDX_D_TOP; k++)
            begin
                role[k] = ebpfs_pkg::ROLE_MEM;
            end
        end
        else
        begin
            role[ebpfs_pkg::IDX_D_PAIR]     = ebpfs_pkg::ROLE_GPIO;
            role[ebpfs_pkg::IDX_D_PAIR + 1] = ebpfs_pkg::ROLE_GPIO;
            if (ainFour_q)
                role[ebpfs_pkg::IDX_D_THIRTY] = ebpfs_pkg::ROLE_ANA;
            if (ainFive_q)
                role[ebpfs_pkg::IDX_D_TOP] = ebpfs_pkg::ROLE_ANA;
        end
    end

    // Registered pad drive
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            padOut_q <= '0;
            padOe_q  <= '0;
        end
        else
        begin
            for (int i = 0; i < ebpfs_pkg::NPINS; i++)
            begin
                case (role[i])
                    ebpfs_pkg::ROLE_GPIO:
                    begin
                        padOut_q[i] <= gpioOut[i];
                        padOe_q[i]  <= gpioDir[i];
                    end
                    ebpfs_pkg::ROLE_MEM:
                    begin
                        padOut_q[i] <= memOut[i];
                        padOe_q[i]  <= memOe[i];
                    end
                    ebpfs_pkg::ROLE_CLK:
                    begin
                        padOut_q[i] <= extClkIn;
                        padOe_q[i]  <= 1'b1;
                    end
                    default:
                    begin
                        padOut_q[i] <= 1'b0;
                        padOe_q[i]  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Analog enables
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            analogEnable_q <= 2'h0;
        else
        begin
            analogEnable_q[0] <= (role[ebpfs_pkg::IDX_D_THIRTY] == ebpfs_pkg::ROLE_ANA);
            analogEnable_q[1] <= (role[ebpfs_pkg::IDX_D_TOP] == ebpfs_pkg::ROLE_ANA);
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    // Skip the capture cycle after release
    default disable iff (sys_rst || strapLoad_q);

    property p_cs_one;
        csOne_q |=> padOe_q[0] == $past(memOe[0]) && padOut_q[0] == $past(memOut[0]);
    endproperty
    a_cs_one: assert property (p_cs_one) else $error("cs one not routed");

    property p_eclk;
        (addrCnt_q != 3'h7 && eclkSel_q) |=> padOe_q[26] && padOut_q[26] == $past(extClkIn);
    endproperty
    a_eclk: assert property (p_eclk) else $error("clock out not routed");

    property p_cs_two;
        csTwo_q != 2'h1 |=> padOe_q[1] == $past(gpioDir[1]);
    endproperty
    a_cs_two: assert property (p_cs_two) else $error("cs two pin not gpio");

    property p_cs_three;
        csThree_q == 2'h1 |=> padOut_q[2] == $past(memOut[2]);
    endproperty
    a_cs_three: assert property (p_cs_three) else $error("cs three not routed");

    property p_dpair;
        !wideBus |=> padOe_q[28:27] == $past(gpioDir[28:27]);
    endproperty
    a_dpair: assert property (p_dpair) else $error("data pair not gpio");

    property p_ain_five;
        (!wideBus && ainFive_q) |=> !padOe_q[30] && analogEnable_q[1];
    endproperty
    a_ain_five: assert property (p_ain_five) else $error("analog five not set");

    property p_strap_zero;
        ($fell(strapLoad_q) && !$past(wrHit)) |-> aZero_q == ($past(strapSync) == 2'h0);
    endproperty
    a_strap_zero: assert property (p_strap_zero) else $error("a0 strap wrong");

    property p_strap_one;
        ($fell(strapLoad_q) && !$past(wrHit)) |-> aOne_q == $past(strapSync[1]);
    endproperty
    a_strap_one: assert property (p_strap_one) else $error("a1 strap wrong");

    property p_span;
        addrCnt_q == 3'h1 |=> padOe_q[6] == $past(memOe[6]) && padOe_q[7] == $past(gpioDir[7]);
    endproperty
    a_span: assert property (p_span) else $error("address span wrong");

    property p_strap_cnt;
        ($fell(strapLoad_q) && !$past(wrHit)) |->
            addrCnt_q == (($past(strapSync) == 2'h3) ? 3'h0 : 3'h7);
    endproperty
    a_strap_cnt: assert property (p_strap_cnt) else $error("span strap wrong");

    property p_wide;
        wideBus |=> !analogEnable_q[0] && padOe_q[29] == $past(memOe[29]);
    endproperty
    a_wide: assert property (p_wide) else $error("wide bus not routed");

    property p_rsvd;
        rdHit |=> regRdata_q[31:28] == 4'h0 && regRdata_q[12] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

    c_cs_one_write: cover property (wrHit && regWdata[11]);
    c_strap_none: cover property (strapLoad_q && strapSync == 2'h3);
    c_wide_bus: cover property (wideBus && ainFive_q);
    c_eclk_out: cover property (eclkSel_q && addrCnt_q == 3'h6);

endmodule

/* File: ebpfs_pkg.sv */
package ebpfs_pkg;

    // Register location
    localparam logic [31:0] REG_OFF      = 32'he002c014;

    // Field positions
    localparam int          BIT_CS_ONE   = 11;
    localparam int          BIT_ECLK     = 13;
    localparam int          CS_TWO_LSB   = 14;
    localparam int          CS_THREE_LSB = 16;
    localparam int          BIT_DPAIR    = 20;
    localparam int          BIT_AIN_FOUR = 21;
    localparam int          BIT_AIN_FIVE = 22;
    localparam int          BIT_A_ZERO   = 23;
    localparam int          BIT_A_ONE    = 24;
    localparam int          ACNT_LSB     = 25;

    // Reset values before the strap capture
    localparam logic        RST_CS_ONE   = 1'h0;
    localparam logic        RST_ECLK     = 1'h0;
    localparam logic [1:0]  RST_CS_TWO   = 2'h0;
    localparam logic [1:0]  RST_CS_THREE = 2'h0;
    localparam logic        RST_DPAIR    = 1'h0;
    localparam logic        RST_AIN_FOUR = 1'h1;
    localparam logic        RST_AIN_FIVE = 1'h1;
    localparam logic        RST_A_ZERO   = 1'h0;
    localparam logic        RST_A_ONE    = 1'h0;
    localparam logic [2:0]  RST_ACNT     = 3'h0;

    // Encodings
    localparam logic [1:0]  CS_FUNC_ON   = 2'h1;
    localparam logic [2:0]  ACNT_NONE    = 3'h0;
    localparam logic [2:0]  ACNT_ALL     = 3'h7;
    localparam logic [1:0]  DBUS_WIDE    = 2'h2;
    localparam logic [1:0]  STRAP_NO_ADR = 2'h3;
    localparam logic [1:0]  STRAP_A_ZERO = 2'h0;

    // Shared pin indices
    localparam int          NPINS        = 31;
    localparam int          IDX_CS_ONE   = 0;
    localparam int          IDX_CS_TWO   = 1;
    localparam int          IDX_CS_THREE = 2;
    localparam int          IDX_A_ZERO   = 3;
    localparam int          IDX_A_ONE    = 4;
    localparam int          IDX_A_TWO    = 5;
    localparam int          IDX_A_TOP    = 26;
    localparam int          IDX_D_PAIR   = 27;
    localparam int          IDX_D_THIRTY = 29;
    localparam int          IDX_D_TOP    = 30;

    typedef enum logic [1:0] {
        ROLE_GPIO = 2'b00,
        ROLE_MEM  = 2'b01,
        ROLE_ANA  = 2'b10,
        ROLE_CLK  = 2'b11
    } ebpfs_role_t;

    // Highest address bit driven for a count code
    function automatic int addrTop(input logic [2:0] cnt);
        case (cnt)
            3'h1:    addrTop = 3;
            3'h2:    addrTop = 5;
            3'h3:    addrTop = 7;
            3'h4:    addrTop = 11;
            3'h5:    addrTop = 15;
            3'h6:    addrTop = 19;
            3'h7:    addrTop = 23;
            default: addrTop = 0;
        endcase
    endfunction

endpackage

/* File: ebpfs_sync2.sv */
`timescale 1ns/1ps
module ebpfs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    logic [W-1:0] stageOne_q;

    // Two stage capture, no reset so it also samples during reset
    always_ff @(posedge core_clk)
    begin
        stageOne_q <= asyncIn;
        syncOut    <= stageOne_q;
    end

endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int          NP      = ebpfs_pkg::NPINS;
    localparam logic [31:0] RW_MASK = 32'h0ff3e800;
    localparam logic [31:0] LEGAL   = 32'h0fe16800;

    logic          core_clk;
    logic          sys_rst;
    logic [31:0]   regAddr;
    logic [31:0]   regWdata;
    logic          regWrEn;
    logic          regRdEn;
    logic [31:0]   regRdata;
    logic [1:0]    bootStrapPins;
    logic [1:0]    dataBusCfg;
    logic [NP-1:0] gpioDir;
    logic [NP-1:0] gpioOut;
    logic [NP-1:0] gpioIn;
    logic [NP-1:0] memOut;
    logic [NP-1:0] memOe;
    logic          extClkIn;
    logic [NP-1:0] padIn;
    logic [NP-1:0] padOut;
    logic [NP-1:0] padOe;
    logic [1:0]    analogEnable;
    logic [NP-1:0] extVal;
    logic [31:0]   img;
    int            n_errors;
    int            check_count;
    int            cyc;

    ebpfs_pin_mux u_ebpfs_pin_mux (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .regAddr       (regAddr),
        .regWdata      (regWdata),
        .regWrEn       (regWrEn),
        .regRdEn       (regRdEn),
        .regRdata      (regRdata),
        .bootStrapPins (bootStrapPins),
        .dataBusCfg    (dataBusCfg),
        .gpioDir       (gpioDir),
        .gpioOut       (gpioOut),
        .gpioIn        (gpioIn),
        .memOut        (memOut),
        .memOe         (memOe),
        .extClkIn      (extClkIn),
        .padIn         (padIn),
        .padOut        (padOut),
        .padOe         (padOe),
        .analogEnable  (analogEnable)
    );

    ebpfs_pad_model u_ebpfs_pad_model (
        .padOut (padOut),
        .padOe  (padOe),
        .extVal (extVal),
        .padIn  (padIn)
    );

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    task automatic results();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        regWrEn  <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrEn  <= 1'b0;
        if (a == ebpfs_pkg::REG_OFF)
            img = d & RW_MASK;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(negedge core_clk);
        chk("regRdata", e, regRdata);
        @(negedge core_clk);
        chk("regRdata idle", 32'h0, regRdata);
        @(posedge core_clk);
    endtask

    function automatic int spanTop(input logic [2:0] c);
        case (c)
            3'h1:    return 3;
            3'h2:    return 5;
            3'h3:    return 7;
            3'h4:    return 11;
            3'h5:    return 15;
            3'h6:    return 19;
            3'h7:    return 23;
            default: return 1;
        endcase
    endfunction

    function automatic ebpfs_pkg::ebpfs_role_t roleOf(input int i);
        logic wide;
        wide = (dataBusCfg === 2'h2);
        if (i == 0) return img[11] ? ebpfs_pkg::ROLE_MEM : ebpfs_pkg::ROLE_GPIO;
        if (i == 1) return (img[15:14] == 2'h1) ? ebpfs_pkg::ROLE_MEM : ebpfs_pkg::ROLE_GPIO;
        if (i == 2) return (img[17:16] == 2'h1) ? ebpfs_pkg::ROLE_MEM : ebpfs_pkg::ROLE_GPIO;
        if (i == 3) return img[23] ? ebpfs_pkg::ROLE_MEM : ebpfs_pkg::ROLE_GPIO;
        if (i == 4) return img[24] ? ebpfs_pkg::ROLE_MEM : ebpfs_pkg::ROLE_GPIO;
        if (i <= 25)
            return (i - 3 <= spanTop(img[27:25])) ? ebpfs_pkg::ROLE_MEM : ebpfs_pkg::ROLE_GPIO;
        if (i == 26)
            return (img[27:25] == 3'h7) ? ebpfs_pkg::ROLE_MEM :
                   (img[13] ? ebpfs_pkg::ROLE_CLK : ebpfs_pkg::ROLE_GPIO);
        if (wide) return ebpfs_pkg::ROLE_MEM;
        if (i == 29 && img[21]) return ebpfs_pkg::ROLE_ANA;
        if (i == 30 && img[22]) return ebpfs_pkg::ROLE_ANA;
        return ebpfs_pkg::ROLE_GPIO;
    endfunction

    task automatic checkPins();
        logic [NP-1:0] eo;
        logic [NP-1:0] eoe;
        logic [NP-1:0] lvl;
        logic          narrow;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        for (int i = 0; i < NP; i++)
        begin
            case (roleOf(i))
                ebpfs_pkg::ROLE_GPIO: begin eo[i] = gpioOut[i]; eoe[i] = gpioDir[i]; end
                ebpfs_pkg::ROLE_MEM:  begin eo[i] = memOut[i];  eoe[i] = memOe[i];   end
                ebpfs_pkg::ROLE_CLK:  begin eo[i] = extClkIn;   eoe[i] = 1'b1;       end
                default:              begin eo[i] = 1'b0;       eoe[i] = 1'b0;       end
            endcase
            lvl[i] = eoe[i] ? eo[i] : extVal[i];
        end
        narrow = (dataBusCfg !== 2'h2);
        chk("padOut", 32'(eo), 32'(padOut));
        chk("padOe", 32'(eoe), 32'(padOe));
        chk("gpioIn", 32'(lvl), 32'(gpioIn));
        chk("analogEnable", 32'({narrow & img[22], narrow & img[21]}), 32'(analogEnable));
        @(posedge core_clk);
    endtask

    task automatic doReset(input logic [1:0] s);
        sys_rst       <= 1'b1;
        bootStrapPins <= s;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // Reset image for every strap setting
    task automatic scnReset();
        logic [31:0] e;
        for (int s = 0; s < 4; s++)
        begin
            doReset(2'(s));
            e = 32'h00600000 | (32'(s == 0) << 23) | (32'(s >> 1) << 24)
                | (32'((s == 3) ? 0 : 7) << 25);
            rd(ebpfs_pkg::REG_OFF, e);
            img = e;
            checkPins();
        end
    endtask

    // Full legal image, reserved bits zero, unmapped place, back to back
    task automatic scnBus();
        wr(ebpfs_pkg::REG_OFF, LEGAL);
        rd(ebpfs_pkg::REG_OFF, LEGAL);
        wr(ebpfs_pkg::REG_OFF + 32'h4, 32'h0);
        rd(ebpfs_pkg::REG_OFF, LEGAL);
        rd(ebpfs_pkg::REG_OFF + 32'h4, 32'h0);
        checkPins();
    endtask

    // Chip select codes 00 and 01 in every pairing
    task automatic scnCs();
        logic [31:0] w;
        for (int c = 0; c < 4; c++)
        begin
            w = (32'(c & 1) << 14) | (32'(c >> 1) << 16) | (32'(c & 1) << 11);
            wr(ebpfs_pkg::REG_OFF, w);
            rd(ebpfs_pkg::REG_OFF, w);
            checkPins();
        end
    endtask

    // Address span codes and clock role
    task automatic scnSpan();
        for (int s = 0; s < 8; s++)
            for (int t = 0; t < 2; t++)
            begin
                extClkIn <= 1'(s & 1);
                wr(ebpfs_pkg::REG_OFF, (32'(s) << 25) | (32'(t) << 13) | (32'(t) << 23)
                   | (32'(1 - t) << 24));
                checkPins();
            end
    endtask

    // Data bus setting against bits 21 and 22
    task automatic scnData();
        for (int c = 0; c < 4; c++)
            for (int b = 0; b < 8; b++)
            begin
                dataBusCfg <= 2'(c);
                wr(ebpfs_pkg::REG_OFF, (32'(b >> 1) << 21) | (32'(b & 1) << 11));
                checkPins();
            end
    endtask

    initial
    begin
        sys_rst       = 1'b1;
        regAddr       = 32'h0;
        regWdata      = 32'h0;
        regWrEn       = 1'b0;
        regRdEn       = 1'b0;
        bootStrapPins = 2'h0;
        dataBusCfg    = 2'h0;
        gpioOut       = 31'h2aaaaaaa;
        gpioDir       = 31'h7c3c3c3c;
        memOut        = 31'h55555555;
        memOe         = 31'h7fffffff;
        extClkIn      = 1'b1;
        extVal        = 31'h33333333;
        img           = 32'h0;
        n_errors      = 0;
        check_count   = 0;
        cyc           = 0;
        @(posedge core_clk);
        scnReset();
        scnBus();
        scnCs();
        scnSpan();
        memOe   <= 31'h0f0f0f0f;
        gpioOut <= 31'h15555555;
        scnData();
        results();
    end
endmodule
